// ===== logic/osc_pkg.sv
// constants, types and latency arithmetic for the sample-timing oscillator
package osc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // architectures
   typedef enum logic [2:0] {
      ARCH_SMALL_TABLE = 3'h0,
      ARCH_LARGE_TABLE = 3'h1,
      ARCH_MULT_LOGIC  = 3'h2,
      ARCH_MULT_DEDIC  = 3'h3,
      ARCH_MULT_HALF   = 3'h4,
      ARCH_ROT_PAR     = 3'h5,
      ARCH_ROT_SER     = 3'h6
   } osc_arch_t;

   // base latencies in cycles
   localparam int BASE_SMALL_TABLE = 7;
   localparam int BASE_LARGE_TABLE = 4;
   localparam int BASE_MULT_LOGIC  = 11;
   localparam int BASE_MULT_SPEC   = 8;
   localparam int BASE_MULT_DEDIC  = 10;
   localparam int BASE_MULT_HALF   = 15;
   localparam int ROT_PAR_ADD      = 4;
   localparam int ROT_SER_ADD      = 2;
   localparam int SPEC_MIN_PREC    = 9;
   localparam int SPEC_MAX_PREC    = 18;
   localparam int DITHER_LAT       = 2;
   localparam int HALF_PERIOD      = 2;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses) and fields
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [3:0]  REG_LATENCY = 4'h8;
   localparam logic [3:0]  REG_SAMPLE  = 4'hC;
   localparam int          CTRL_RUN    = 0;
   localparam int          CTRL_CLRCNT = 1;
   localparam logic [1:0]  CTRL_RESET  = 2'h1;
   localparam logic [15:0] LFSR_SEED   = 16'hACE1;

   // wishbone request carrier
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [3:0]  adr;
      logic [31:0] dat;
   } osc_wbreq_t;

   // total latency from input take to qualified output
   function automatic int latency(osc_arch_t arch, int n, bit dual, bit dith,
                                  int fmPipe, int pmPipe);
      int base;
      int add;
      add = fmPipe + pmPipe;
      unique case (arch)
         ARCH_SMALL_TABLE: base = BASE_SMALL_TABLE;
         ARCH_LARGE_TABLE: base = BASE_LARGE_TABLE;
         ARCH_MULT_LOGIC:  base = BASE_MULT_LOGIC;
         ARCH_MULT_DEDIC:  base = (n >= SPEC_MIN_PREC && n <= SPEC_MAX_PREC && dual)
                                  ? BASE_MULT_SPEC : BASE_MULT_DEDIC;
         ARCH_MULT_HALF:   base = BASE_MULT_HALF;
         ARCH_ROT_PAR:     base = 2 * n + ROT_PAR_ADD;
         default:          base = 2 * n + ROT_SER_ADD;
      endcase
      if (arch == ARCH_ROT_SER) begin
         add = add * n;
      end
      return base + (dith ? DITHER_LAT : 0) + add;
   endfunction : latency

   // enabled cycles between two samples
   function automatic int period(osc_arch_t arch, int n);
      return (arch == ARCH_ROT_SER) ? n : ((arch == ARCH_MULT_HALF) ? HALF_PERIOD : 1);
   endfunction : period

endpackage : osc_pkg

// ===== logic/osc_delay_line.sv
// enable-gated shift pipeline of fixed depth
`timescale 1ns/1ps
`default_nettype none
module osc_delay_line #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // stream
   input  wire logic             advance,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage_ff [DEPTH];

   // every stage holds while advance is low, so a paused pipe resumes intact
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) stage_ff[i] <= '0;
      end else if (advance) begin
         stage_ff[0] <= din;
         for (int i = 1; i < DEPTH; i++) stage_ff[i] <= stage_ff[i-1];
      end
   end

   assign dout = stage_ff[DEPTH-1];
endmodule : osc_delay_line
`default_nettype wire

// ===== logic/osc_wave_lookup.sv
// quarter-wave sine table giving sine and cosine of a phase word
`timescale 1ns/1ps
`default_nettype none
module osc_wave_lookup #(
   parameter int MAG_W = 12
) (
   // phase in
   input  wire logic [5:0]       phase,
   // samples out
   output logic      [MAG_W-1:0] sinVal,
   output logic      [MAG_W-1:0] cosVal
);
   // quarter wave, 16 points, amplitude 32767 before scaling
   function automatic logic [15:0] quarter(logic [3:0] idx);
      logic [15:0] t [16];
      t = '{16'h0000, 16'h0C8B, 16'h18F8, 16'h2527, 16'h30FB, 16'h3C56, 16'h471C,
            16'h5133, 16'h5A82, 16'h62F1, 16'h6A6D, 16'h70E2, 16'h7641, 16'h7A7C,
            16'h7D89, 16'h7F61};
      return t[idx];
   endfunction : quarter

   // full wave from quadrant folding; truncation keeps only the top bits
   function automatic logic [MAG_W-1:0] wave(logic [5:0] ph);
      logic [15:0] mag;
      logic [3:0]  idx;
      logic [15:0] signedMag;
      // second quadrant mirrors about the quarter point, so the index is 16 - k
      idx = ph[4] ? 4'(~ph[3:0] + 4'h1) : ph[3:0];
      mag = (ph[4] && ph[3:0] == 4'h0) ? 16'h7FFF : quarter(idx);
      signedMag = ph[5] ? 16'(-mag) : mag;
      return signedMag[15 -: MAG_W];
   endfunction : wave

   assign sinVal = wave(phase);
   assign cosVal = wave(6'(phase + 6'h10));
endmodule : osc_wave_lookup
`default_nettype wire

// ===== logic/osc_sample_core.sv
// oscillator core: phase accumulation, output cadence, latency pipe, wishbone
`timescale 1ns/1ps
`default_nettype none
module osc_sample_core #(
   parameter osc_pkg::osc_arch_t ARCH = osc_pkg::ARCH_SMALL_TABLE,
   parameter int ACC_W    = 32,
   parameter int MAG_W    = 12,
   parameter int FM_W     = 16,
   parameter int PM_W     = 16,
   parameter bit DUAL     = 1'b1,
   parameter bit DITHER   = 1'b0,
   parameter int FM_PIPE  = 0,
   parameter int PM_PIPE  = 0,
   parameter int CHANNELS = 1
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // driver side
   input  wire logic              clken,
   input  wire logic [ACC_W-1:0]  phiInc,
   input  wire logic [FM_W-1:0]   freqMod,
   input  wire logic [PM_W-1:0]   phaseMod,
   // sample stream, no ready
   output logic      [MAG_W-1:0]  sinOut,
   output logic      [MAG_W-1:0]  cosOut,
   output logic                   outValid,
   output logic      [7:0]        outChannel,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [3:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o
);
   localparam int LAT    = osc_pkg::latency(ARCH, MAG_W, DUAL, DITHER, FM_PIPE, PM_PIPE);
   localparam int PERIOD = osc_pkg::period(ARCH, MAG_W);
   localparam int CH_W   = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
   localparam int PER_W  = (PERIOD > 1) ? $clog2(PERIOD) : 1;
   // lookup is combinational; the output register adds one stage, the pipe makes up the rest
   localparam int PIPE_D = LAT - 1;
   localparam int PKT_W  = 1 + 8 + 2 * MAG_W;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone request and control registers
   osc_pkg::osc_wbreq_t req;
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                  adr: wb_adr_i, dat: wb_dat_i};

   logic [1:0]  ctrl_ff;
   logic [1:0]  nxt_ctrl;
   logic        ack_ff;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;
   logic [31:0] sampleCnt_ff;
   logic [31:0] nxt_sampleCnt;

   // a request is answered one cycle after it appears, then ack drops
   wire access   = req.cyc & req.stb & ~ack_ff;
   wire wrCtrl   = access & req.we & req.sel[0] & (req.adr == osc_pkg::REG_CTRL);
   wire clrCount = wrCtrl & req.dat[osc_pkg::CTRL_CLRCNT];

   ////////////////////////////////////////////////////////////////////////////
   // advance term: cadence, channel, dither, accumulator and pipe state move only on enabled cycles
   wire advance  = clken & ctrl_ff[osc_pkg::CTRL_RUN];

   ////////////////////////////////////////////////////////////////////////////
   // cadence counter: one input take per PERIOD enabled cycles
   logic [PER_W-1:0] slot_ff;
   logic [PER_W-1:0] nxt_slot;
   wire              lastSlot = (slot_ff == PER_W'(PERIOD - 1));
   wire              take     = advance & (slot_ff == '0);

   // cadence wraps every PERIOD enabled cycles; full rate stays at zero
   assign nxt_slot = !advance ? slot_ff
                   : (lastSlot ? '0 : PER_W'(slot_ff + 1'b1));

   ////////////////////////////////////////////////////////////////////////////
   // channel rotation and per-channel accumulators
   logic [CH_W-1:0]  chan_ff;
   logic [CH_W-1:0]  nxt_chan;
   logic [ACC_W-1:0] acc_ff [CHANNELS];
   logic [15:0]      lfsr_ff;
   logic [15:0]      nxt_lfsr;

   // channel 0 is taken on the first enabled edge after reset
   assign nxt_chan = !take ? chan_ff
                   : ((chan_ff == CH_W'(CHANNELS - 1)) ? '0 : CH_W'(chan_ff + 1'b1));

   // frequency word sign-extended to the accumulator width, phase word placed at its top bits
   wire [ACC_W-1:0] fmExt  = ACC_W'(signed'(freqMod));
   wire [ACC_W-1:0] pmExt  = {phaseMod, {(ACC_W - PM_W){1'b0}}};
   wire [ACC_W-1:0] accCur = acc_ff[chan_ff];
   wire [ACC_W-1:0] accNxt = accCur + phiInc + fmExt;
   wire [ACC_W-1:0] phMod  = accCur + pmExt;

   // dither nudges bits below the table index; small LFSR keeps cost low
   wire [ACC_W-1:0] dithWord = DITHER ? ACC_W'({lfsr_ff[1:0], {(ACC_W - 8){1'b0}}}) : '0;
   assign nxt_lfsr = advance ? {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12]
                                ^ lfsr_ff[10]} : lfsr_ff;
   wire [ACC_W-1:0] phFinal  = phMod + dithWord;

   ////////////////////////////////////////////////////////////////////////////
   // sine and cosine of the current phase
   wire [MAG_W-1:0] sinNow;
   wire [MAG_W-1:0] cosNow;

   osc_wave_lookup #(
      .MAG_W (MAG_W)
   ) u_lookup (
      .phase  (phFinal[ACC_W-1 -: 6]),
      .sinVal (sinNow),
      .cosVal (cosNow)
   );

   ////////////////////////////////////////////////////////////////////////////
   // latency pipe: qualifier, channel and both samples travel together
   logic [PKT_W-1:0] firstStage_ff;
   logic [PKT_W-1:0] nxt_firstStage;
   wire  [PKT_W-1:0] pipeOut;

   // non-take slots carry a low qualifier so the sink skips them
   assign nxt_firstStage = !advance ? firstStage_ff
                         : {take, 8'(chan_ff), sinNow,
                            DUAL ? cosNow : {MAG_W{1'b0}}};

   osc_delay_line #(
      .WIDTH (PKT_W),
      .DEPTH (PIPE_D)
   ) u_pipe (
      .clk     (clk),
      .rst     (rst),
      .advance (advance),
      .din     (firstStage_ff),
      .dout    (pipeOut)
   );

   // field split of the pipe head
   wire             pipeValid = pipeOut[PKT_W-1];
   wire [7:0]       pipeChan  = pipeOut[PKT_W-2 -: 8];
   wire [MAG_W-1:0] pipeSin   = pipeOut[2*MAG_W-1 -: MAG_W];
   wire [MAG_W-1:0] pipeCos   = pipeOut[MAG_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // output stage: pipe head registered straight to the pins
   logic             valid_ff;
   logic [7:0]       chanOut_ff;
   logic [MAG_W-1:0] sin_ff;
   logic [MAG_W-1:0] cos_ff;

   // qualifier follows the pipe so it rises with the first channel 0 result
   wire             nxt_valid  = advance & pipeValid;
   // data keeps moving between qualified samples; only the qualifier marks them
   wire [MAG_W-1:0] nxt_sin    = advance ? pipeSin : sin_ff;
   wire [MAG_W-1:0] nxt_cos    = advance ? pipeCos : cos_ff;
   wire [7:0]       nxt_chanOut = advance ? pipeChan : chanOut_ff;

   // samples counted as emitted; no ready input so nothing can stall here
   assign nxt_sampleCnt = clrCount ? '0
                        : (nxt_valid ? 32'(sampleCnt_ff + 1'b1) : sampleCnt_ff);

   ////////////////////////////////////////////////////////////////////////////
   // register readback decode
   wire [31:0] latencyWord = 32'(LAT);
   wire [31:0] sampleWord  = {{(32 - 2 * MAG_W){1'b0}}, sin_ff, cos_ff};
   wire [31:0] ctrlWord    = {30'h00000000, ctrl_ff};

   assign nxt_rdat = (req.adr == osc_pkg::REG_CTRL)    ? ctrlWord
                   : (req.adr == osc_pkg::REG_STATUS)  ? sampleCnt_ff
                   : (req.adr == osc_pkg::REG_LATENCY) ? latencyWord
                   : (req.adr == osc_pkg::REG_SAMPLE)  ? sampleWord
                   : 32'h00000000;

   // run bit written, clear bit is a self-clearing strobe
   assign nxt_ctrl = wrCtrl ? {1'b0, req.dat[osc_pkg::CTRL_RUN]} : {1'b0, ctrl_ff[0]};

   ////////////////////////////////////////////////////////////////////////////
   // bus registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= osc_pkg::CTRL_RESET;
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ctrl_ff <= nxt_ctrl;
         ack_ff  <= access;
         rdat_ff <= access ? nxt_rdat : rdat_ff;
      end
   end

   // cadence, channel and dither state
   always_ff @(posedge clk) begin
      if (rst) begin
         slot_ff <= '0;
         chan_ff <= '0;
         lfsr_ff <= osc_pkg::LFSR_SEED;
      end else begin
         slot_ff <= nxt_slot;
         chan_ff <= nxt_chan;
         lfsr_ff <= nxt_lfsr;
      end
   end

   // accumulators step only on a take for the channel being served
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < CHANNELS; i++) acc_ff[i] <= '0;
      end else if (take) begin
         acc_ff[chan_ff] <= accNxt;
      end
   end

   // first pipe stage and output registers
   always_ff @(posedge clk) begin
      if (rst) begin
         firstStage_ff <= '0;
         valid_ff      <= 1'b0;
         chanOut_ff    <= 8'h00;
         sin_ff        <= '0;
         cos_ff        <= '0;
         sampleCnt_ff  <= 32'h00000000;
      end else begin
         firstStage_ff <= nxt_firstStage;
         valid_ff      <= nxt_valid;
         chanOut_ff    <= nxt_chanOut;
         sin_ff        <= nxt_sin;
         cos_ff        <= nxt_cos;
         sampleCnt_ff  <= nxt_sampleCnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins
   assign sinOut     = sin_ff;
   assign cosOut     = cos_ff;
   assign outValid   = valid_ff;
   assign outChannel = chanOut_ff;
   assign wb_dat_o   = rdat_ff;
   assign wb_ack_o   = ack_ff;

endmodule : osc_sample_core
`default_nettype wire

// ===== tb/osc_sink_model.sv
// downstream sink model: takes every qualified sample, never stalls
`timescale 1ns/1ps
`default_nettype none
module osc_sink_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // sample stream
   input  wire logic outValid,
   // capture record
   output var  int   sampleCnt
);
   // no ready exists, so a beat not taken here is lost for good
   always @(posedge clk) begin
      if (rst) begin
         sampleCnt <= 0;
      end else if (outValid === 1'b1) begin
         sampleCnt <= sampleCnt + 1;
      end
   end
endmodule : osc_sink_model
`default_nettype wire

// ===== tb/osc_sample_core_sva.sv
// port-level timing checks for the oscillator core
`timescale 1ns/1ps
`default_nettype none
module osc_sample_core_sva #(
   parameter bit DITHER   = 1'b0,
   parameter int MAG_W    = 12,
   parameter int FM_PIPE  = 0,
   parameter int PM_PIPE  = 0,
   parameter int CHANNELS = 1
) (
   // clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // stream
   input wire logic             clken,
   input wire logic [MAG_W-1:0] sinOut,
   input wire logic             outValid,
   input wire logic [7:0]       outChannel,
   // wishbone
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [3:0]       wb_adr_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // latency figure holds for the small table build only
   localparam int LAT = osc_pkg::BASE_SMALL_TABLE + (DITHER ? osc_pkg::DITHER_LAT : 0)
                        + FM_PIPE + PM_PIPE;
   logic [7:0] enTotFf;
   logic       seenFf;
   wire        rdReq = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   // enabled edges since reset, saturating so it cannot wrap
   always_ff @(posedge clk) begin
      if (rst) begin
         enTotFf <= 8'h00;
         seenFf  <= 1'b0;
      end else begin
         enTotFf <= enTotFf + {7'h00, clken && enTotFf != 8'hFF};
         seenFf  <= seenFf | outValid;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_lat_on; enTotFf > LAT && $past(clken) |-> outValid; endproperty
   a_lat_on: assert property (p_lat_on) else $error("sample missing");
   property p_lat_off; enTotFf <= LAT |-> !outValid; endproperty
   a_lat_off: assert property (p_lat_off) else $error("sample early");
   property p_freeze; !clken |=> !outValid; endproperty
   a_freeze: assert property (p_freeze) else $error("valid while frozen");
   property p_hold; !clken |=> $stable(sinOut) && $stable(outChannel); endproperty
   a_hold: assert property (p_hold) else $error("output moved frozen");
   property p_reset; $fell(rst) |-> !outValid && sinOut == '0 && outChannel == 8'h00; endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_first; outValid && !seenFf |-> outChannel == 8'h00; endproperty
   a_first: assert property (p_first) else $error("first not channel 0");
   property p_seq;
      outValid ##1 outValid |-> outChannel ==
         (($past(outChannel) == CHANNELS - 1) ? 8'h00 : $past(outChannel) + 8'h01);
   endproperty
   a_seq: assert property (p_seq) else $error("channel order");
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_unmap; rdReq && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_latreg; rdReq && wb_adr_i == 4'h8 |=> wb_dat_o == LAT; endproperty
   a_latreg: assert property (p_latreg) else $error("latency register");
endmodule : osc_sample_core_sva
bind osc_sample_core osc_sample_core_sva #(
   .DITHER(DITHER), .MAG_W(MAG_W), .FM_PIPE(FM_PIPE), .PM_PIPE(PM_PIPE), .CHANNELS(CHANNELS)
) u_sva (
   .clk(clk), .rst(rst), .clken(clken), .sinOut(sinOut), .outValid(outValid),
   .outChannel(outChannel), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// ===== tb/tb_osc_sample_core.sv
// bench for the oscillator core: cadence, latency, channels, registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module tb_osc_sample_core;
   localparam int CHN = 2;
   localparam int LAT = 7 + 2 + 1; // small table, dither, one fm stage
   localparam logic [11:0] PEAK = 12'h7FF; // full positive scale of a 12-bit sample
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                clken = 1'b0;
   logic [31:0]         phiInc = 32'h0;
   logic [31:0]         rnd = 32'h25;
   logic [15:0]         freqMod = 16'h0;
   logic [15:0]         phaseMod = 16'h0;
   logic [11:0]         sinOut;
   logic [11:0]         cosOut;
   logic                outValid;
   logic [7:0]          outChannel;
   osc_pkg::osc_wbreq_t wbReq = '0;
   logic [31:0]         wbDat;
   logic                wbAck;
   int                  num_errors = 0;
   int                  comparisons = 0;
   int                  enCnt = 0;
   int                  takeIdx = 0;
   int                  sinkCnt;
   int                  base;
   logic [31:0]         sQ[$];
   logic [32:0]         bQ[$];
   logic [24:0]         vQ[$];
   int                  sinkBase;
   always #25 clk = ~clk;
   osc_sample_core #(.DITHER(1'b1), .FM_PIPE(1), .CHANNELS(CHN)) dut_u (
      .clk(clk), .rst(rst), .clken(clken), .phiInc(phiInc), .freqMod(freqMod),
      .phaseMod(phaseMod), .sinOut(sinOut), .cosOut(cosOut), .outValid(outValid),
      .outChannel(outChannel), .wb_cyc_i(wbReq.cyc), .wb_stb_i(wbReq.stb),
      .wb_we_i(wbReq.we), .wb_sel_i(wbReq.sel), .wb_adr_i(wbReq.adr),
      .wb_dat_i(wbReq.dat), .wb_dat_o(wbDat), .wb_ack_o(wbAck)
   );
   osc_sink_model sink_u (.clk(clk), .rst(rst), .outValid(outValid), .sampleCnt(sinkCnt));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   // enabled edges since reset; a take's index is its place in this count
   always @(posedge clk) enCnt <= rst ? 0 : enCnt + int'(clken);
   // each enabled edge takes a new word, so each is noted
   task automatic stream(int n, bit randEn, bit en0);
      bit en;
      repeat (n) begin
         rnd = xs(rnd);
         en = randEn ? (rnd[0] | rnd[1]) : en0;
         clken    <= en;
         phiInc   <= rnd;
         freqMod  <= rnd[31:16];
         phaseMod <= rnd[15:0];
         if (en) sQ.push_back({24'(takeIdx), 8'(takeIdx % CHN)});
         if (en) vQ.push_back(25'h0);
         takeIdx += int'(en);
         @(posedge clk);
      end
   endtask : stream
   // fixed offset, zero increment: from a cleared accumulator the phase is the offset
   task automatic steady(int n, logic [15:0] pm, logic [11:0] es, logic [11:0] ec);
      repeat (n) begin
         clken    <= 1'b1;
         phiInc   <= 32'h0;
         freqMod  <= 16'h0;
         phaseMod <= pm;
         sQ.push_back({24'(takeIdx), 8'(takeIdx % CHN)});
         vQ.push_back({1'b1, es, ec});
         takeIdx++;
         @(posedge clk);
      end
   endtask : steady
   // classic single wishbone cycle, ack awaited under a bound
   task automatic wb(bit we, logic [3:0] adr, logic [31:0] dat, bit chk, logic [31:0] e);
      int t;
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
      bQ.push_back({chk & ~we, e});
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1 && t < 20);
      if (wbAck !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
      wbReq <= '0;
      @(posedge clk);
   endtask : wb
   // results against the oldest note, at the edge they are seen
   always @(posedge clk) begin : mon
      logic [31:0] n;
      logic [32:0] b;
      logic [24:0] v;
      if (rst === 1'b0 && outValid === 1'b1) begin
         n = (sQ.size() > 0) ? sQ.pop_front() : 32'hFFFFFFFF;
         v = (vQ.size() > 0) ? vQ.pop_front() : 25'h0;
         `CHK("take index", n[31:8], 24'(enCnt - 1 - LAT))
         `CHK("channel", n[7:0], outChannel)
         if (v[24]) `CHK("sine", v[23:12], sinOut)
         if (v[24]) `CHK("cosine", v[11:0], cosOut)
      end
      if (wbAck === 1'b1 && bQ.size() > 0) begin
         b = bQ.pop_front();
         if (b[32]) `CHK("read data", b[31:0], wbDat)
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      stream(40, 0, 1);
      $display("test full_rate done");
      stream(300, 1, 0);
      stream(3, 0, 0);
      `CHK("in flight", LAT, sQ.size())
      $display("test pauses done");
      wb(0, osc_pkg::REG_LATENCY, 32'h0, 1, 32'(LAT));
      wb(0, 4'h1, 32'h0, 1, 32'h0);
      wb(1, 4'h2, 32'hFFFFFFFF, 0, 32'h0);
      wb(0, 4'h2, 32'h0, 1, 32'h0);
      wb(0, osc_pkg::REG_CTRL, 32'h0, 1, 32'h1);
      wb(1, osc_pkg::REG_CTRL, 32'h3, 0, 32'h0);
      // the frozen pipe holds LAT takes, so the window emits as many samples as it takes
      base = takeIdx;
      sinkBase = sinkCnt;
      stream(60, 1, 0);
      stream(3, 0, 0);
      `CHK("sink count", takeIdx - base, sinkCnt - sinkBase)
      wb(0, osc_pkg::REG_STATUS, 32'h0, 1, 32'(takeIdx - base));
      $display("test registers done");
      // reset with work in flight; the pipe must come back empty
      stream(20, 0, 1);
      rst <= 1'b1;
      @(posedge clk);
      sQ.delete();
      vQ.delete();
      takeIdx = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      steady(12, 16'h0000, 12'h000, PEAK);
      steady(12, 16'h4000, PEAK, 12'h000);
      stream(3, 0, 0);
      `CHK("in flight", LAT, sQ.size())
      wb(0, osc_pkg::REG_SAMPLE, 32'h0, 1, {8'h00, PEAK, 12'h000});
      $display("test reset done");
      end_of_test();
   end
endmodule : tb_osc_sample_core
`default_nettype wire
